// >>> shf_pkg.sv
// Package for the serial packet framer and settings negotiation block
package shf_pkg;
  // Packet type indicators
  localparam logic [7:0] TYPE_CMD = 8'h01;
  localparam logic [7:0] TYPE_ACL = 8'h02;
  localparam logic [7:0] TYPE_SCO = 8'h03;
  localparam logic [7:0] TYPE_EVT = 8'h04;
  localparam logic [7:0] TYPE_ERR = 8'h05;
  localparam logic [7:0] TYPE_NEG = 8'h06;
  // Settings byte field positions
  localparam int STOP_BIT = 2;
  localparam int PAR_EN_BIT = 3;
  localparam int PAR_TYPE_BIT = 4;
  localparam int ACK_LSB = 5;
  // Acknowledge codes
  localparam logic [2:0] ACK_REQ = 3'h0;
  localparam logic [2:0] ACK_OK = 3'h1;
  localparam logic [2:0] ACK_NAK = 3'h2;
  // Protocol mode bits
  localparam int MODE_CRC_BIT = 0;
  localparam int MODE_DELIM_BIT = 1;
  localparam int MODE_RTS_BIT = 2;
  localparam int MODE_RTSMODE_BIT = 3;
  localparam int MODE_ERREC_BIT = 4;
  localparam int MODE_EXT_LSB = 5;
  localparam logic [7:0] MODE_DEFAULT = 8'h13;
  localparam int MAX_EXT = 7;
  // Baud rate reference and default divisor for 9600 bps
  localparam int BAUD_REF_HZ = 27648000;
  localparam int DEFAULT_BAUD_BPS = 9600;
  localparam logic [15:0] DEFAULT_DIV = 16'(BAUD_REF_HZ / DEFAULT_BAUD_BPS);
  localparam logic [7:0] DEFAULT_SETTINGS = 8'h00;
  // Negotiation packet body length after the sequence number
  localparam logic [3:0] NEG_BODY_LEN = 4'h6;
  // Link settings carried together
  typedef struct packed {
    logic [15:0] divisor;
    logic two_stop;
    logic par_en;
    logic par_even;
    logic [7:0] mode;
  } shf_cfg_t;
  // Byte stream beat
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } shf_beat_t;
endpackage : shf_pkg

// >>> shf_framer.sv
// Serial packet framer with controller-side settings negotiation
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Every packet starts with one type byte: 01 cmd, 02 ACL, 03 SCO, 04 event.
// - Commands only arrive from host; events only leave the controller.
// - Type 05 is an error message, type 06 a negotiation packet.
// - An 8-bit sequence number follows the type, incremented per new packet.
// - Body follows the sequence number; length field sizes host packets.
// - Error and negotiation packets are fixed length, negotiation plus up to 7; the block ends a received negotiation packet at the mode byte.
// - Multi-byte fields are little endian, low byte sent first.
// - Controller starts at default settings and waits for host negotiation.
// - Accepting controller echoes settings with its latency and code 001b.
// - Controller switches settings only after host's final 001b packet.
// - Unacceptable settings get new suggestions with code 010b; repeat.
// - Renegotiation may start any time and uses current settings.
// - Defaults: 9600 bps, no parity, 8 data bits, 1 stop, mode 13.
// - Settings byte: stop bit 2, parity 3, type 4, ack bits 5-7.
// - Stop 1 means two; parity enable 1 on; type 1 even, 0 odd.
// - Baud divisor N gives 27.648 MHz over N; zero is rejected.
// - Detect latency is in 100 us units.
// - Mode bit 0 appends a CRC, set by default.
// - CRC is x16+x12+x5+1, usable with either sync method.
// - Mode bit 1 selects 7E delimiters with byte stuffing, default set.
// - Mode bit 2 enables RTS/CTS; bit 3 picks flow control or resync.
// - Mode bit 4 enables error recovery, set by default.
// - Mode bits 5-7 count extra negotiation bytes.
module shf_framer
  import shf_pkg::*;
#(
  parameter logic [15:0] LOCAL_DETECT = 16'h0001,
  parameter logic [15:0] MIN_DIV = 16'h0001,
  parameter logic [7:0] SUPPORTED_MODE = 8'h1F
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Received byte stream, already deframed
  input wire shf_pkg::shf_beat_t rx_beat,
  // Outgoing payload request: type and body bytes from the controller core
  input wire logic [7:0] tx_type,
  input wire shf_pkg::shf_beat_t tx_body,
  output logic tx_body_ready,
  // Transmit byte stream to the line encoder
  output shf_pkg::shf_beat_t tx_beat,
  input wire logic tx_ready,
  // Received host packet delivered to the core
  output shf_pkg::shf_beat_t host_beat,
  output logic [7:0] host_type,
  output logic rx_bad_type,
  // Live link settings and remote latency
  output shf_pkg::shf_cfg_t link_cfg,
  output logic [15:0] remote_detect,
  output logic negotiated
);
  import shf_pkg::*;

  typedef enum logic [2:0] {
    SHF_TX_IDLE = 3'b000,
    SHF_TX_TYPE = 3'b001,
    SHF_TX_SEQ = 3'b011,
    SHF_TX_BODY = 3'b010,
    SHF_TX_NEG = 3'b110
  } shf_tx_t;

  typedef enum logic [1:0] {
    SHF_RX_TYPE = 2'b00,
    SHF_RX_SEQ = 2'b01,
    SHF_RX_BODY = 2'b11
  } shf_rx_t;

  typedef struct packed {
    shf_tx_t tx_st;
    shf_rx_t rx_st;
    logic [7:0] tx_seq;
    logic [7:0] cur_type;
    logic [3:0] tx_idx;
    logic [7:0] rx_type;
    logic [3:0] rx_idx;
    logic [3:0] rx_len;
    logic [7:0] rx_set;
    logic [15:0] rx_div;
    logic [15:0] rx_det;
    logic [7:0] rx_mode;
    logic reply_pend;
    logic [2:0] reply_ack;
    shf_cfg_t reply_cfg;
    logic wait_final;
    shf_cfg_t pend_cfg;
    shf_cfg_t live_cfg;
    logic [15:0] rem_det;
    logic done;
    shf_beat_t tx_out;
    shf_beat_t host_out;
    logic [7:0] host_typ;
    logic bad_type;
    logic body_rdy;
  } shf_state_t;

  shf_state_t st;
  shf_state_t next_st;

  // Negotiation reply bytes, low byte first on multi-byte fields
  function automatic logic [7:0] neg_byte(input logic [3:0] idx,
                                          input shf_cfg_t c,
                                          input logic [2:0] ack);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      4'h0: begin
        b[STOP_BIT] = c.two_stop;
        b[PAR_EN_BIT] = c.par_en;
        b[PAR_TYPE_BIT] = c.par_even;
        b[ACK_LSB +: 3] = ack;
      end
      4'h1: b = c.divisor[7:0];
      4'h2: b = c.divisor[15:8];
      4'h3: b = LOCAL_DETECT[7:0];
      4'h4: b = LOCAL_DETECT[15:8];
      4'h5: b = {3'h0, c.mode[4:0]};
      default: b = 8'h00;
    endcase
    return b;
  endfunction : neg_byte

  shf_cfg_t default_cfg;
  shf_cfg_t sugg_cfg;
  logic [2:0] rx_ack;
  logic [15:0] fin_div;
  logic [7:0] fin_mode;
  logic accept;
  logic tx_take;

  // Default link settings, entered at reset
  always_comb begin
    default_cfg = '0;
    default_cfg.divisor = DEFAULT_DIV;
    default_cfg.mode = MODE_DEFAULT;
  end

  // Decision on a completed negotiation packet
  always_comb begin
    rx_ack = st.rx_set[ACK_LSB +: 3];
    fin_div = {rx_beat.data, st.rx_div[7:0]};
    fin_mode = st.rx_mode;
    // Reserved codes and zero or too fast divisors are not acceptable
    accept = (rx_ack <= ACK_NAK) && (st.rx_div != 16'h0000)
             && (st.rx_div >= MIN_DIV)
             && ((st.rx_mode & ~SUPPORTED_MODE & 8'h1F) == 8'h00);
    sugg_cfg = st.live_cfg;
    sugg_cfg.divisor = (st.rx_div < MIN_DIV) ? MIN_DIV : st.rx_div;
    sugg_cfg.mode = (st.rx_mode & SUPPORTED_MODE) | MODE_DEFAULT;
    sugg_cfg.mode[MODE_EXT_LSB +: 3] = 3'h0;
  end

  assign tx_take = !st.tx_out.valid || tx_ready;

  // Next-state logic for both directions
  always_comb begin
    next_st = st;
    next_st.bad_type = 1'b0;
    next_st.host_out.valid = 1'b0;
    next_st.body_rdy = 1'b0;
    if (tx_ready) begin
      next_st.tx_out.valid = 1'b0;
    end
    // Receive side: type, sequence number, then body
    if (rx_beat.valid) begin
      unique case (st.rx_st)
        SHF_RX_TYPE: begin
          next_st.rx_type = rx_beat.data;
          next_st.rx_idx = 4'h0;
          next_st.rx_len = NEG_BODY_LEN;
          // Events and unknown types never come from the host
          if (rx_beat.data == TYPE_EVT || rx_beat.data == 8'h00 ||
              rx_beat.data > TYPE_NEG) begin
            next_st.bad_type = 1'b1;
          end else begin
            next_st.rx_st = SHF_RX_SEQ;
          end
        end
        SHF_RX_SEQ: next_st.rx_st = SHF_RX_BODY;
        SHF_RX_BODY: begin
          next_st.rx_idx = st.rx_idx + 4'h1;
          if (st.rx_type == TYPE_NEG) begin
            unique case (st.rx_idx)
              4'h0: next_st.rx_set = rx_beat.data;
              4'h1: next_st.rx_div[7:0] = rx_beat.data;
              4'h2: next_st.rx_div[15:8] = rx_beat.data;
              4'h3: next_st.rx_det[7:0] = rx_beat.data;
              4'h4: next_st.rx_det[15:8] = rx_beat.data;
              4'h5: begin
                next_st.rx_mode = rx_beat.data;
                // Expansion count goes into rx_len, but the packet still ends at the mode byte
                next_st.rx_len = NEG_BODY_LEN +
                  {1'b0, rx_beat.data[MODE_EXT_LSB +: 3]};
              end
              default: ;
            endcase
            if (st.rx_idx == st.rx_len - 4'h1 && st.rx_idx >= 4'h5) begin
              next_st.rx_st = SHF_RX_TYPE;
            end
          end else begin
            // Host packets pass through; the core tracks the length field
            next_st.host_out = '{valid: 1'b1, last: rx_beat.last,
                                 data: rx_beat.data};
            next_st.host_typ = st.rx_type;
            if (rx_beat.last) begin
              next_st.rx_st = SHF_RX_TYPE;
            end
          end
          if (rx_beat.last) begin
            next_st.rx_st = SHF_RX_TYPE;
          end
        end
        default: next_st.rx_st = SHF_RX_TYPE;
      endcase
    end
    // Mode byte seen: act on the negotiation packet once
    if (rx_beat.valid && st.rx_st == SHF_RX_BODY && st.rx_type == TYPE_NEG
        && st.rx_idx == 4'h5) begin
      next_st.rem_det = st.rx_det;
      if (rx_ack == ACK_OK && st.wait_final) begin
        next_st.live_cfg = st.pend_cfg;
        next_st.wait_final = 1'b0;
        next_st.done = 1'b1;
      end else if (accept && rx_ack != ACK_OK) begin
        next_st.pend_cfg.divisor = st.rx_div;
        next_st.pend_cfg.two_stop = st.rx_set[STOP_BIT];
        next_st.pend_cfg.par_en = st.rx_set[PAR_EN_BIT];
        next_st.pend_cfg.par_even = st.rx_set[PAR_TYPE_BIT];
        next_st.pend_cfg.mode = rx_beat.data;
        next_st.reply_cfg = next_st.pend_cfg;
        next_st.reply_ack = ACK_OK;
        next_st.reply_pend = 1'b1;
        next_st.wait_final = 1'b1;
        next_st.done = 1'b0;
      end else if (rx_ack != ACK_OK) begin
        next_st.reply_cfg = sugg_cfg;
        next_st.reply_ack = ACK_NAK;
        next_st.reply_pend = 1'b1;
        next_st.wait_final = 1'b0;
      end
    end
    // Transmit side
    if (tx_take) begin
      unique case (st.tx_st)
        SHF_TX_IDLE: begin
          if (st.reply_pend) begin
            next_st.cur_type = TYPE_NEG;
            next_st.tx_st = SHF_TX_TYPE;
          end else if (tx_body.valid && !st.body_rdy && tx_type != TYPE_CMD
                       && tx_type != 8'h00 && tx_type <= TYPE_ERR
                       && st.done) begin
            next_st.cur_type = tx_type;
            next_st.tx_st = SHF_TX_TYPE;
          end
        end
        SHF_TX_TYPE: begin
          next_st.tx_out = '{valid: 1'b1, last: 1'b0, data: st.cur_type};
          next_st.tx_st = SHF_TX_SEQ;
        end
        SHF_TX_SEQ: begin
          next_st.tx_out = '{valid: 1'b1, last: 1'b0, data: st.tx_seq};
          next_st.tx_seq = st.tx_seq + 8'h01;
          next_st.tx_idx = 4'h0;
          next_st.tx_st = (st.cur_type == TYPE_NEG) ? SHF_TX_NEG
                                                    : SHF_TX_BODY;
        end
        SHF_TX_BODY: begin
          // One body byte per accepted beat from the core; while the ready
          // pulse stands the core still shows the byte already taken
          if (tx_body.valid && !st.body_rdy) begin
            next_st.tx_out = tx_body;
            next_st.body_rdy = 1'b1;
            if (tx_body.last) begin
              next_st.tx_st = SHF_TX_IDLE;
            end
          end
        end
        SHF_TX_NEG: begin
          next_st.tx_out = '{valid: 1'b1,
                             last: st.tx_idx == NEG_BODY_LEN - 4'h1,
                             data: neg_byte(st.tx_idx, st.reply_cfg,
                                            st.reply_ack)};
          next_st.tx_idx = st.tx_idx + 4'h1;
          if (st.tx_idx == NEG_BODY_LEN - 4'h1) begin
            next_st.reply_pend = 1'b0;
            next_st.tx_st = SHF_TX_IDLE;
          end
        end
        default: next_st.tx_st = SHF_TX_IDLE;
      endcase
    end
    // Body ready only pulses while the byte is really taken
    if (!(tx_take && st.tx_st == SHF_TX_BODY)) begin
      next_st.body_rdy = 1'b0;
    end
  end

  // State register; controller begins at defaults waiting for the host
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
      st.live_cfg <= default_cfg;
      st.pend_cfg <= default_cfg;
      st.reply_cfg <= default_cfg;
    end else begin
      st <= next_st;
    end
  end

  // Registered outputs
  always_comb begin
    tx_beat = st.tx_out;
    tx_body_ready = st.body_rdy;
    host_beat = st.host_out;
    host_type = st.host_typ;
    rx_bad_type = st.bad_type;
    link_cfg = st.live_cfg;
    remote_detect = st.rem_det;
    negotiated = st.done;
  end

  // Settings change only via a final acknowledgement
  live_switch_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st.live_cfg != $past(st.live_cfg)) |-> $past(st.wait_final))
    else $error("settings changed without final acknowledgement");

  // Sequence number steps by one per sent sequence byte
  seq_step_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st.tx_st == SHF_TX_SEQ && tx_take) |=> (st.tx_seq ==
      $past(st.tx_seq) + 8'h01))
    else $error("sequence number did not advance");

  // A sequence byte always follows the type byte
  type_then_seq_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st.tx_st == SHF_TX_TYPE && tx_take) |=> (st.tx_out.valid &&
      st.tx_st == SHF_TX_SEQ))
    else $error("type byte not followed by sequence state");

  // Never send a command packet
  no_cmd_out_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st.tx_st == SHF_TX_TYPE) |-> (st.cur_type != TYPE_CMD))
    else $error("controller framed a command packet");

  // Reset leaves default settings
  reset_default_a: assert property (@(posedge ref_clk)
    $fell(reset) |-> (st.live_cfg.divisor == DEFAULT_DIV &&
      st.live_cfg.mode == MODE_DEFAULT))
    else $error("defaults not loaded at reset");

  // Reply acknowledge codes are only accepted or not accepted
  reply_ack_a: assert property (@(posedge ref_clk) disable iff (reset)
    st.reply_pend |-> (st.reply_ack == ACK_OK || st.reply_ack == ACK_NAK))
    else $error("illegal reply acknowledge code");

  // Zero divisor never becomes live
  zero_div_a: assert property (@(posedge ref_clk) disable iff (reset)
    st.live_cfg.divisor != 16'h0000)
    else $error("zero baud divisor in use");

  // Negotiation reply ends after its sixth body beat, marked last
  sequence neg_last_s;
    st.tx_st == SHF_TX_NEG && tx_take && st.tx_idx == NEG_BODY_LEN - 4'h1;
  endsequence
  neg_len_a: assert property (@(posedge ref_clk) disable iff (reset)
    neg_last_s |=> (st.tx_st == SHF_TX_IDLE && st.tx_out.last))
    else $error("negotiation reply length wrong");
endmodule : shf_framer
`default_nettype wire

// >>> shf_host_model.sv
// Host side model: feeds received bytes and paces transmit acceptance
`timescale 1ns/1ps
`default_nettype none
module shf_host_model
  import shf_pkg::*;
(
  // Clock and pacing
  input wire logic ref_clk,
  input wire logic stall,
  // Toward the block
  output var shf_pkg::shf_beat_t rx_beat,
  output var logic tx_ready
);
  logic [7:0] last_data;
  initial begin
    rx_beat = '0;
    tx_ready = 1'b0;
    last_data = 8'h00;
  end
  // Random stalls force the block to hold some reply bytes
  always @(posedge ref_clk) tx_ready <= #1 !stall;
  // One byte per strobe; idle data shows the inverse, never a stale copy
  task automatic put(input logic [7:0] b, input logic l);
    @(posedge ref_clk);
    #1;
    rx_beat = '{valid: 1'b1, last: l, data: b};
    last_data = b;
    @(posedge ref_clk);
    #1;
    rx_beat = '{valid: 1'b0, last: 1'b0, data: ~last_data};
  endtask : put
  // Settings packet, 16-bit fields low byte first
  task automatic send_neg(input logic [7:0] seq, input logic [7:0] set,
                          input logic [15:0] div, input logic [15:0] det);
    put(TYPE_NEG, 1'b0);
    put(seq, 1'b0);
    put(set, 1'b0);
    put(div[7:0], 1'b0);
    put(div[15:8], 1'b0);
    put(det[7:0], 1'b0);
    put(det[15:8], 1'b0);
    put(MODE_DEFAULT, 1'b1);
  endtask : send_neg
endmodule : shf_host_model
`default_nettype wire

// >>> serial_hci_framing_negotiation_tb.sv
// Self-checking bench for the framer and settings negotiation
`timescale 1ns/1ps
`default_nettype none
module serial_hci_framing_negotiation_tb;
  import shf_pkg::*;
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] data;
  } shf_exp_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  shf_beat_t rx_beat, tx_body, tx_beat, host_beat;
  logic [7:0] tx_type = 8'h00;
  logic tx_body_ready, tx_ready, rx_bad_type, negotiated, stall;
  logic [7:0] host_type;
  shf_cfg_t link_cfg;
  logic [15:0] remote_detect;
  logic [15:0] lfsr = 16'hF3F1;
  logic [7:0] tx_seq = 8'h00;
  shf_exp_t tx_q[$];
  shf_exp_t host_q[$];
  shf_exp_t e;
  int bad_count = 0;
  int samples_checked = 0;
  int bad_seen = 0;
  int cycles = 0;
  initial tx_body = '0;
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  always @(posedge ref_clk) lfsr <= lfsr_next(lfsr);
  assign stall = lfsr[0] & lfsr[3];
  shf_framer DUT (.ref_clk(ref_clk), .reset(reset), .rx_beat(rx_beat),
    .tx_type(tx_type), .tx_body(tx_body), .tx_body_ready(tx_body_ready),
    .tx_beat(tx_beat), .tx_ready(tx_ready), .host_beat(host_beat),
    .host_type(host_type), .rx_bad_type(rx_bad_type),
    .link_cfg(link_cfg), .remote_detect(remote_detect),
    .negotiated(negotiated));
  shf_host_model HOST (.ref_clk(ref_clk), .stall(stall),
    .rx_beat(rx_beat), .tx_ready(tx_ready));
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // Hang guard: a run far beyond the expected length is a failure
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // Watcher: every accepted output byte takes the oldest note
  always @(posedge ref_clk) begin
    if (!reset && tx_beat.valid === 1'b1 && tx_ready === 1'b1) begin
      e = (tx_q.size() > 0) ? tx_q.pop_front() : '{8'hFF, ~tx_beat.data};
      check("tx_byte", tx_beat.data & e.mask, e.data & e.mask);
    end
    if (!reset && host_beat.valid === 1'b1) begin
      e = (host_q.size() > 0) ? host_q.pop_front() : '{8'hFF, 8'hFF};
      check("host_type", host_type, e.mask);
      check("host_byte", host_beat.data, e.data);
    end
    if (!reset && rx_bad_type === 1'b1) bad_seen++;
  end
  // Reply notes; m masks body fields the block may choose itself
  task automatic expect_neg(input logic [7:0] set, input logic [15:0] div,
                            input logic [7:0] m);
    tx_q.push_back('{8'hFF, TYPE_NEG});
    tx_q.push_back('{8'hFF, tx_seq});
    tx_seq++;
    tx_q.push_back('{m | 8'hE0, set});
    tx_q.push_back('{m, div[7:0]});
    tx_q.push_back('{m, div[15:8]});
    tx_q.push_back('{m, 8'h01});
    tx_q.push_back('{m, 8'h00});
    tx_q.push_back('{m, MODE_DEFAULT});
  endtask : expect_neg
  task automatic drain;
    while (tx_q.size() > 0) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    #2;
  endtask : drain
  task automatic host_pkt(input logic [7:0] t, input logic [7:0] seq);
    logic [7:0] b[$];
    b = '{8'h2A, 8'h00, 8'h01};
    if (t == TYPE_ACL) b.push_back(8'h00);
    b.push_back(lfsr[7:0]);
    HOST.put(t, 1'b0);
    HOST.put(seq, 1'b0);
    foreach (b[i]) begin
      host_q.push_back('{t, b[i]});
      HOST.put(b[i], i == b.size() - 1);
    end
  endtask : host_pkt
  task automatic core_send(input logic [7:0] t, input int n);
    logic [7:0] d;
    tx_q.push_back('{8'hFF, t});
    tx_q.push_back('{8'hFF, tx_seq});
    tx_seq++;
    for (int i = 0; i < n; i++) begin
      d = lfsr[7:0];
      tx_q.push_back('{8'hFF, d});
      tx_type = t;
      tx_body = '{valid: 1'b1, last: i == n - 1, data: d};
      do @(posedge ref_clk); while (tx_body_ready !== 1'b1);
      #1;
    end
    tx_body = '0;
  endtask : core_send
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    @(posedge ref_clk);
    #2;
    check("cfg_rst", link_cfg, {DEFAULT_DIV, 3'b000, MODE_DEFAULT});
    check("neg_rst", negotiated, 1'b0);
    check("tx_rst", tx_beat.valid, 1'b0);
    // Reserved ack code, then zero divisor: both refused
    expect_neg(8'h40, 16'h0000, 8'h00);
    HOST.send_neg(8'h00, 8'h7C, 16'h0010, 16'h0005);
    drain();
    expect_neg(8'h40, 16'h0000, 8'h00);
    HOST.send_neg(8'h01, 8'h1C, 16'h0000, 16'h0005);
    drain();
    // Acceptable request is echoed with the block's latency
    expect_neg(8'h3C, 16'h0010, 8'hFF);
    HOST.send_neg(8'h02, 8'h1C, 16'h0010, 16'h0005);
    drain();
    check("cfg_hold", link_cfg.divisor, DEFAULT_DIV);
    check("neg_hold", negotiated, 1'b0);
    HOST.send_neg(8'h03, 8'h3C, 16'h0010, 16'h0005);
    drain();
    check("cfg_new", link_cfg, {16'h0010, 3'b111, MODE_DEFAULT});
    check("neg_done", negotiated, 1'b1);
    check("rdetect", remote_detect, 16'h0005);
    // Event and unknown types from the host are refused
    HOST.put(TYPE_EVT, 1'b1);
    HOST.put(8'h07, 1'b1);
    host_pkt(TYPE_CMD, 8'h04);
    host_pkt(TYPE_ACL, 8'h05);
    host_pkt(TYPE_SCO, 8'h06);
    core_send(TYPE_ACL, 3);
    core_send(TYPE_SCO, 1);
    drain();
    check("bad_types", bad_seen, 2);
    check("host_left", host_q.size(), 0);
    check("tx_left", tx_q.size(), 0);
    stop_test();
  end
endmodule : serial_hci_framing_negotiation_tb
`default_nettype wire
